/* rtl/psr_regs.svh */
// Overview of operation
// RL1: A page-field write makes the written value the new active page.
// RL2: Reading the page field returns the currently active page.
// RL3: Write-only two-bit slot number picks one of four save slots.
// RL4: Code 10 saves the active page into the slot, then loads the new page.
// RL5: Code 11 replaces the active page with the selected slot contents.
// RL6: During restore, page bits written with the command are ignored.
// RL7: Slot number 00,01,10,11 selects slots zero, one, two, three.
// RL8: Bits 7 and 3 read zero; other writes update only the page.
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH
`define PSR_PAGE_OFFSET   12'h000
`define PSR_PAGE_RESET    8'h00
`define PSR_PAGE_LSB      0
`define PSR_PAGE_MSB      2
`define PSR_SLOT_LSB      4
`define PSR_SLOT_MSB      5
`define PSR_CODE_LSB      6
`define PSR_CODE_MSB      7
`define PSR_CODE_SAVE     2'b10
`define PSR_CODE_RESTORE  2'b11
`define PSR_SLOT_COUNT    4
`define PSR_RESP_OKAY     2'b00
`define PSR_RESP_SLVERR   2'b10
`endif

/* rtl/psr_pkg.sv */
package psr_pkg;
  typedef logic [2:0] psr_page_t;
  typedef logic [1:0] psr_slot_t;
  typedef struct packed {
    logic      valid;
    logic [1:0] code;
    psr_slot_t slot;
    psr_page_t page;
  } psr_cmd_s;
endpackage

/* rtl/psr_bank.sv */
`timescale 1ns/1ps
`include "psr_regs.svh"
module psr_bank (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // Decoded write command
  input  wire psr_pkg::psr_cmd_s cmd,
  // Active page
  output logic [2:0]             active_page
);
  psr_pkg::psr_page_t slots      [`PSR_SLOT_COUNT];
  psr_pkg::psr_page_t next_slots [`PSR_SLOT_COUNT];
  psr_pkg::psr_page_t next_page;

  // Next page and slot contents from the command
  always_comb
  begin
    next_page = active_page;
    for (int i = 0; i < `PSR_SLOT_COUNT; i++)
    begin
      next_slots[i] = slots[i];
    end
    if (cmd.valid)
    begin
      case (cmd.code)
        `PSR_CODE_SAVE:
        begin
          next_slots[cmd.slot] = active_page; // RL4 RL7
          next_page = cmd.page;               // RL4
        end
        `PSR_CODE_RESTORE:
        begin
          next_page = slots[cmd.slot];        // RL5 RL6 RL7
        end
        default:
        begin
          next_page = cmd.page;               // RL1 RL8
        end
      endcase
    end
  end

  // Register page and slots
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_page <= 3'h0;
      for (int i = 0; i < `PSR_SLOT_COUNT; i++)
      begin
        slots[i] <= 3'h0;
      end
    end
    else
    begin
      active_page <= next_page;
      slots       <= next_slots;
    end
  end
endmodule // psr_bank

/* rtl/psr_top.sv */
`timescale 1ns/1ps
`include "psr_regs.svh"
module psr_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Active page to the shared window decode
  output logic [2:0]       active_page
);
  logic              aw_held;
  logic [11:0]       aw_addr;
  logic              w_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              next_aw_held;
  logic [11:0]       next_aw_addr;
  logic              next_w_held;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              do_write;
  logic              hit_w;
  psr_pkg::psr_cmd_s cmd;

  // Register address match, used for both directions
  function automatic logic is_page_addr(input logic [11:0] a);
    return a[11:2] == 10'(`PSR_PAGE_OFFSET >> 2);
  endfunction

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write commits when both address and data are present
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = next_aw_held && next_w_held && !s_axi_bvalid;
    hit_w    = is_page_addr(next_aw_addr);
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    cmd.valid   = do_write && hit_w && next_w_strb[0];
    cmd.code    = next_w_data[`PSR_CODE_MSB:`PSR_CODE_LSB];
    cmd.slot    = next_w_data[`PSR_SLOT_MSB:`PSR_SLOT_LSB]; // RL3
    cmd.page    = next_w_data[`PSR_PAGE_MSB:`PSR_PAGE_LSB];
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    if (do_write)
    begin
      next_bvalid = 1'b1;
      next_bresp  = hit_w ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
    end
  end

  // Read path: page field live, all other bits zero
  always_comb
  begin
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0000_0000;
      next_rresp  = `PSR_RESP_SLVERR;
      if (is_page_addr(s_axi_araddr))
      begin
        next_rdata[`PSR_PAGE_MSB:`PSR_PAGE_LSB] = active_page; // RL2 RL8
        next_rresp = `PSR_RESP_OKAY;
      end
    end
  end

  // Bus state registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= 12'h000;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else
    begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // Page and save slot storage
  psr_bank u_bank (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .cmd         (cmd),
    .active_page (active_page)
  );
endmodule // psr_top

/* testbench/psr_asserts.sv */
`timescale 1ns/1ps
module psr_asserts (
  // Watched top ports
  input wire logic        sys_clk, arst_n, s_axi_awvalid, s_axi_awready,
  input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_rvalid,
  input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic [2:0]  active_page
);
  logic [2:0] slot [4];
  logic       wr;
  logic [1:0] op;
  // Accepted page-register write and its operation code
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == 12'h000 && s_axi_wstrb[0];
  assign op = s_axi_wdata[7:6];
  // Shadow of the save slots
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) slot <= '{default: 3'h0};
    else if (wr && op == 2'b10) slot[s_axi_wdata[5:4]] <= active_page;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_page_write: assert property (wr && !op[1] |=> active_page == $past(s_axi_wdata[2:0]))
    else $error("page write");
  a_save_load: assert property (wr && op == 2'b10 |=> active_page == $past(s_axi_wdata[2:0]))
    else $error("save load");
  a_restore_slot: assert property (wr && op == 2'b11
    |=> active_page == $past(slot[s_axi_wdata[5:4]])) else $error("restore");
  a_page_hold: assert property (!wr |=> $stable(active_page))
    else $error("page hold");
  a_read_page: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) == 12'h000
    |-> s_axi_rdata[2:0] == $past(active_page)) else $error("read page");
  a_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:3] == 29'h0)
    else $error("read zero");
  a_write_answer: assert property (wr |=> s_axi_bvalid) else $error("no answer");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("busy");
endmodule // psr_asserts
bind psr_top psr_asserts u_chk (.*);

/* testbench/psr_tb_top.sv */
`timescale 1ns/1ps
module psr_tb_top;
  logic        sys_clk = 1'b0, arst_n = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, a;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h0, s;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  active_page, pg = 3'h0;
  logic [2:0]  sl [4] = '{default: 3'h0};
  logic [33:0] rq [$];
  logic [4:0]  bq [$];
  int          num_errors = 0, check_count = 0, seed = 32'h4216_39c7;
  psr_top dut (.*);
  always #10 sys_clk = ~sys_clk;
  // Compare one read result
  task automatic chk(logic [33:0] e, logic [33:0] v);
    check_count++;
    if (v !== e)
    begin
      num_errors++;
      $display("MISMATCH read expected %h seen %h", e, v);
    end
  endtask
  // Compare one write answer: response code and the page it leaves active
  task automatic chk_wr(logic [4:0] e, logic [4:0] v);
    check_count++;
    if (v !== e)
    begin
      num_errors++;
      $display("MISMATCH write expected %h seen %h", e, v);
    end
  endtask
  // Oldest expectation against each write answer
  always @(posedge sys_clk)
    if (s_axi_bvalid && s_axi_bready) chk_wr(bq.pop_front(), {s_axi_bresp, active_page});
  // Oldest expectation against each read answer
  always @(posedge sys_clk)
    if (s_axi_rvalid && s_axi_rready) chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  // Write: address and data together, then the response
  task automatic wr();
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Read: address, then the data
  task automatic rd();
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Random writes over all codes and slots, each read back
  initial
  begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 64; i++)
    begin
      d = $random(seed);
      d[7:6] = i[1:0];
      a = (i % 7 == 6) ? 12'h004 : 12'h000;
      s = (i % 5 == 4) ? 4'h0 : 4'h1;
      if (a == 12'h000 && s[0])
      begin
        if (d[7:6] == 2'b10) sl[d[5:4]] = pg;
        pg = (d[7:6] == 2'b11) ? sl[d[5:4]] : d[2:0];
      end
      bq.push_back({(a == 12'h000) ? 2'b00 : 2'b10, pg});
      wr();
      rq.push_back({(a == 12'h000) ? 2'b00 : 2'b10, 29'h0, (a == 12'h000) ? pg : 3'h0});
      rd();
    end
    $display("test random_ops done");
    complete_run();
  end
  // Watchdog against a hang
  initial
  begin
    #100us;
    num_errors++;
    complete_run();
  end
endmodule // psr_tb_top
